//--- rtl/qamcd_pkg.sv
package qamcd_pkg;

  // ------------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------------
  localparam logic [6:0]  CONVERTER_CONTROL_ADDR = 7'h01;
  localparam logic [15:0] CONVERTER_CONTROL_RST  = 16'h0000;
  localparam logic [15:0] CTRL_RESERVED_MASK     = 16'h2800;

  // ------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------
  localparam int MODE_LSB  = 0;
  localparam int PDF_LSB   = 4;
  localparam int CODE_BIT  = 7;
  localparam int BW_BIT    = 8;
  localparam int RES11_BIT = 11;
  localparam int TEST_BIT  = 12;
  localparam int RES13_BIT = 13;

  // ------------------------------------------------------------------
  // Serial frame: read flag (0 = write), 7-bit address, 16-bit data
  // ------------------------------------------------------------------
  localparam int          FRAME_BITS = 24;
  localparam logic [4:0]  FRAME_LAST = 5'h17;

  // ------------------------------------------------------------------
  // Codes
  // ------------------------------------------------------------------
  localparam logic [1:0] PD_NONE = 2'h0;
  localparam logic [1:0] PD_LOW  = 2'h1;
  localparam logic [1:0] PD_HIGH = 2'h2;
  localparam logic [1:0] PD_ALL  = 2'h3;

  localparam logic [3:0] MODE_AC = 4'h4;
  localparam logic [3:0] MODE_BC = 4'h5;
  localparam logic [3:0] MODE_AD = 4'h6;
  localparam logic [3:0] MODE_BD = 4'h7;

  // Core power-down enables, one bit per core
  typedef struct packed {
    logic core_d;
    logic core_c;
    logic core_b;
    logic core_a;
  } qamcd_pd_t;

  typedef enum logic [1:0] {
    QAMCD_FOUR  = 2'b00,
    QAMCD_TWO   = 2'b01,
    QAMCD_OTHER = 2'b10
  } qamcd_mode_t;

endpackage : qamcd_pkg

//--- rtl/qamcd_top.sv
`timescale 1ns/1ps

// Function
// - Bit 8 selects bandwidth; bits 13 and 11 are reserved, forced to zero.
// - Bit 12 enables test mode; pattern comes from separate test register.
// - Mode bits 3:2 zero gives four-channel; code 11 powers down all.
// - Four-channel: code 01 powers down A and B, 10 powers down C and D.
// - Mode 0100: code 01 powers down A, 10 powers down C, 11 both.
// - Standby code 00 keeps all cores powered in two or four-channel modes.
// - Mode 0101: code 01 powers down B, 10 powers down C, 11 both.
// - Mode 0110: code 01 powers down A, 10 powers down D, 11 both.
// - Mode 0111: code 01 powers down B, 10 powers down D, 11 both.
// - Standby bits 5:4, mode bits 3:0, bit 7 selects Gray coding.
module qamcd_top
  import qamcd_pkg::*;
(
  input  wire logic        i_clk_sys,
  input  wire logic        i_rstn,
  input  wire logic        i_cfg_sel_n,
  input  wire logic        i_cfg_sdi,
  output logic             o_cfg_sdo,
  output logic             o_cfg_sdo_oe,
  output qamcd_pd_t        o_core_pd,
  output logic             o_bandwidth_select,
  output logic             o_test_enable,
  output logic             o_gray_coding,
  output qamcd_mode_t      o_mode_class,
  output logic             o_combo_error
);

  // ------------------------------------------------------------------
  // Serial frame capture
  // ------------------------------------------------------------------
  logic [4:0]             bit_cnt;
  logic [FRAME_BITS-1:0]  shift;
  logic [15:0]            converter_control;
  logic [15:0]            rd_shift;

  wire       frame_active = !i_cfg_sel_n;
  wire [FRAME_BITS-1:0] next_shift = {shift[FRAME_BITS-2:0], i_cfg_sdi};
  wire       frame_done   = frame_active && (bit_cnt == FRAME_LAST);
  wire       hdr_done     = frame_active && (bit_cnt == 5'h07);
  wire       is_write     = !next_shift[FRAME_BITS-1];
  wire [6:0] frame_addr   = next_shift[22:16];
  wire       addr_hit     = (frame_addr == CONVERTER_CONTROL_ADDR);
  wire       hdr_read     = next_shift[7] && (next_shift[6:0] ==
                                             CONVERTER_CONTROL_ADDR);
  wire [15:0] wr_value    = next_shift[15:0] & ~CTRL_RESERVED_MASK;
  wire       wr_commit    = frame_done && is_write && addr_hit;

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      bit_cnt <= 5'h00;
      shift   <= '0;
    end else if (!frame_active) begin
      bit_cnt <= 5'h00;
    end else begin
      shift   <= next_shift;
      bit_cnt <= frame_done ? 5'h00 : bit_cnt + 5'h01;
    end
  end

  // register loads only at frame end
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      converter_control <= CONVERTER_CONTROL_RST;
    end else if (wr_commit) begin
      converter_control <= wr_value;
    end
  end

  // Read-back: data shifted out after a read header
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      rd_shift     <= 16'h0000;
      o_cfg_sdo    <= 1'b0;
      o_cfg_sdo_oe <= 1'b0;
    end else if (!frame_active) begin
      o_cfg_sdo_oe <= 1'b0;
      o_cfg_sdo    <= 1'b0;
    end else if (hdr_done && hdr_read) begin
      o_cfg_sdo_oe <= 1'b1;
      o_cfg_sdo    <= converter_control[15];
      rd_shift     <= {converter_control[14:0], 1'b0};
    end else if (frame_done) begin
      o_cfg_sdo_oe <= 1'b0;
      o_cfg_sdo    <= 1'b0;
    end else begin
      o_cfg_sdo    <= rd_shift[15];
      rd_shift     <= {rd_shift[14:0], 1'b0};
    end
  end

  // ------------------------------------------------------------------
  // Field decode
  // ------------------------------------------------------------------
  // field positions
  wire [1:0] power_down_code       = converter_control[PDF_LSB+:2];
  wire [3:0] interleave_mode_field = converter_control[MODE_LSB+:4];
  wire       four_mode = (interleave_mode_field[3:2] == 2'b00);
  wire       two_mode  = (interleave_mode_field[3:2] == 2'b01);
  wire       pd_lo     = power_down_code[0];
  wire       pd_hi     = power_down_code[1];

  wire qamcd_pd_t pd_four = '{core_a: pd_lo, core_b: pd_lo,
                              core_c: pd_hi, core_d: pd_hi};

  // code 00 leaves every core on
  wire first_b  = interleave_mode_field[0];
  wire second_d = interleave_mode_field[1];
  wire qamcd_pd_t pd_two  = '{core_a: pd_lo && !first_b,
                              core_b: pd_lo &&  first_b,
                              core_c: pd_hi && !second_d,
                              core_d: pd_hi &&  second_d};

  wire qamcd_pd_t next_pd = four_mode ? pd_four :
                            two_mode  ? pd_two  :
                            qamcd_pd_t'({4{power_down_code != PD_NONE}});

  // pairing outside the supported set flagged
  wire next_combo_error = !(four_mode || two_mode);

  wire qamcd_mode_t next_mode = four_mode ? QAMCD_FOUR :
                                two_mode  ? QAMCD_TWO  : QAMCD_OTHER;

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      o_core_pd          <= '0;
      o_bandwidth_select <= 1'b0;
      o_test_enable      <= 1'b0;
      o_gray_coding      <= 1'b0;
      o_mode_class       <= QAMCD_FOUR;
      o_combo_error      <= 1'b0;
    end else begin
      o_core_pd          <= next_pd;
      o_bandwidth_select <= converter_control[BW_BIT];
      o_test_enable      <= converter_control[TEST_BIT];
      o_gray_coding      <= converter_control[CODE_BIT];
      o_mode_class       <= next_mode;
      o_combo_error      <= next_combo_error;
    end
  end

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  sequence s_commit;
    wr_commit;
  endsequence

  a_hold_no_write: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    !wr_commit |=> $stable(converter_control))
    else $error("control changed without write");

  a_commit_load: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    s_commit |=> converter_control == $past(wr_value))
    else $error("write not loaded");

  a_reserved_zero: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    !converter_control[RES13_BIT] && !converter_control[RES11_BIT])
    else $error("reserved bit set");

  a_bw_follow: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    s_commit |=> ##1 o_bandwidth_select == $past(wr_value[BW_BIT], 2))
    else $error("bandwidth wrong");

  a_test_follow: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    s_commit |=> ##1 o_test_enable == $past(wr_value[TEST_BIT], 2))
    else $error("test enable wrong");

  a_four_full: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    four_mode && power_down_code == PD_ALL |=> o_core_pd == 4'hF)
    else $error("four-channel full standby wrong");

  a_four_part: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    four_mode && power_down_code == PD_LOW |=> o_core_pd == 4'h3)
    else $error("four-channel A/B standby wrong");

  a_no_standby: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    (four_mode || two_mode) && power_down_code == PD_NONE
      |=> o_core_pd == 4'h0)
    else $error("standby 00 powered down a core");

  a_pair_ac: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    interleave_mode_field == MODE_AC && power_down_code == PD_HIGH
      |=> o_core_pd == 4'h4)
    else $error("A/C pairing wrong");

  a_pair_bc: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    interleave_mode_field == MODE_BC && power_down_code == PD_LOW
      |=> o_core_pd == 4'h2)
    else $error("B/C pairing wrong");

  a_pair_ad: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    interleave_mode_field == MODE_AD && power_down_code == PD_HIGH
      |=> o_core_pd == 4'h8)
    else $error("A/D pairing wrong");

  a_pair_bd: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    interleave_mode_field == MODE_BD && power_down_code == PD_ALL
      |=> o_core_pd == 4'hA)
    else $error("B/D pairing wrong");

endmodule : qamcd_top

//--- tb/qamcd_host_model.sv
`timescale 1ns/1ps

module qamcd_host_model
  import qamcd_pkg::*;
(
  input  wire logic i_clk_sys,
  input  wire logic i_cfg_sdo,
  output logic      o_cfg_sel_n,
  output logic      o_cfg_sdi,
  output logic      o_sync_in_pos,
  output logic      o_sync_in_neg
);
  logic sync_on = 1'b0;

  initial begin
    o_cfg_sel_n = 1'b1;
    o_cfg_sdi   = 1'b0;
  end

  assign o_sync_in_pos = sync_on & i_clk_sys;
  assign o_sync_in_neg = ~o_sync_in_pos;

  // --------------------------------------------------------------
  // Frame: nbits below 24 gives an aborted frame
  // --------------------------------------------------------------
  task automatic frame(input logic rd_flag, input logic [6:0] addr,
                       input logic [15:0] data, input int nbits,
                       output logic [15:0] rdata);
    logic [23:0] word;
    word  = {rd_flag, addr, data};
    rdata = 16'h0000;
    if (!rd_flag && addr == CONVERTER_CONTROL_ADDR && nbits == FRAME_BITS)
      sync_on = data[TEST_BIT];
    for (int i = 0; i < nbits; i++) begin
      @(negedge i_clk_sys);
      if (i >= 8)
        rdata = {rdata[14:0], i_cfg_sdo};
      o_cfg_sel_n = 1'b0;
      o_cfg_sdi   = word[23 - i];
    end
    @(negedge i_clk_sys);
    o_cfg_sel_n = 1'b1;
    o_cfg_sdi   = ~o_cfg_sdi;
  endtask : frame
endmodule : qamcd_host_model

//--- tb/quad_adc_mode_control_decode_tb.sv
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin checks_done++; if ((gt) !== (ex)) begin \
  n_mismatch++; $display("Error %s exp %0h got %0h", nm, ex, gt); end end

module quad_adc_mode_control_decode_tb
  import qamcd_pkg::*;
;
  typedef struct packed {
    logic [15:0] wr;
    logic [3:0]  pd;
    qamcd_mode_t cls;
  } qamcd_row_t;

  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        sel_n, sdi, sdo, bw, test, gray, err;
  qamcd_pd_t   pd;
  qamcd_mode_t cls;
  logic [15:0] rd;
  logic [3:0]  prev = 4'h0;
  int          n_mismatch = 0;
  int          checks_done = 0;
  logic        sdo_oe;
  int          oe_cnt = 0;
  int          oe_base = 0;

  qamcd_row_t rows[17] = '{
    '{16'h0003, 4'h0, QAMCD_FOUR}, '{16'h0113, 4'h3, QAMCD_FOUR},
    '{16'h10A0, 4'hC, QAMCD_FOUR}, '{16'h2832, 4'hF, QAMCD_FOUR},
    '{16'h0004, 4'h0, QAMCD_TWO},  '{16'h0014, 4'h1, QAMCD_TWO},
    '{16'h0824, 4'h4, QAMCD_TWO},  '{16'h01B4, 4'h5, QAMCD_TWO},
    '{16'h0015, 4'h2, QAMCD_TWO},  '{16'h1025, 4'h4, QAMCD_TWO},
    '{16'h0035, 4'h6, QAMCD_TWO},  '{16'h0016, 4'h1, QAMCD_TWO},
    '{16'h0026, 4'h8, QAMCD_TWO},  '{16'h2136, 4'h9, QAMCD_TWO},
    '{16'h0017, 4'h2, QAMCD_TWO},  '{16'h0127, 4'h8, QAMCD_TWO},
    '{16'h10B7, 4'hA, QAMCD_TWO}};

  always #50 clk = ~clk;

  // Counts falling edges with read data driven
  always @(negedge clk)
    if (sdo_oe === 1'b1)
      oe_cnt++;

  qamcd_top dut_u (.i_clk_sys(clk), .i_rstn(rstn), .i_cfg_sel_n(sel_n),
    .i_cfg_sdi(sdi), .o_cfg_sdo(sdo), .o_cfg_sdo_oe(sdo_oe), .o_core_pd(pd),
    .o_bandwidth_select(bw), .o_test_enable(test), .o_gray_coding(gray),
    .o_mode_class(cls), .o_combo_error(err));

  qamcd_host_model host_u (.i_clk_sys(clk), .i_cfg_sdo(sdo),
    .o_cfg_sel_n(sel_n), .o_cfg_sdi(sdi), .o_sync_in_pos(),
    .o_sync_in_neg());

  task automatic check_out(input logic [15:0] w, input logic [3:0] epd,
                           input qamcd_mode_t ecls, input logic eerr);
    `CHK("core_pd", epd, pd)
    `CHK("bandwidth", w[BW_BIT], bw)
    `CHK("test_enable", w[TEST_BIT], test)
    `CHK("gray", w[CODE_BIT], gray)
    `CHK("mode_class", ecls, cls)
    `CHK("combo_error", eerr, err)
  endtask : check_out

  task automatic give_verdict();
    if (n_mismatch == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : give_verdict

  // --------------------------------------------------------------
  // Watchdog
  // --------------------------------------------------------------
  initial begin
    #500_000;
    n_mismatch++;
    give_verdict();
  end

  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    repeat (10) @(negedge clk);
    rstn = 1'b1;
    for (int k = 0; k < 17; k++) begin
      oe_base = oe_cnt;
      host_u.frame(1'b0, CONVERTER_CONTROL_ADDR, rows[k].wr, FRAME_BITS, rd);
      `CHK("pd_hold", prev, pd)
      @(negedge clk);
      check_out(rows[k].wr, rows[k].pd, rows[k].cls, 1'b0);
      host_u.frame(1'b1, CONVERTER_CONTROL_ADDR, 16'h0000, FRAME_BITS, rd);
      `CHK("readback", rows[k].wr & ~CTRL_RESERVED_MASK, rd)
      `CHK("sdo_oe_cycles", oe_base + 16, oe_cnt)
      prev = rows[k].pd;
    end
    // Aborted frame and foreign address leave state alone
    host_u.frame(1'b0, CONVERTER_CONTROL_ADDR, 16'h0033, 12, rd);
    repeat (2) @(negedge clk);
    `CHK("abort_pd", 4'hA, pd)
    host_u.frame(1'b0, 7'h02, 16'h0033, FRAME_BITS, rd);
    @(negedge clk);
    `CHK("addr_pd", 4'hA, pd)
    // One-channel mode with partial standby
    host_u.frame(1'b0, CONVERTER_CONTROL_ADDR, 16'h0018, FRAME_BITS, rd);
    @(negedge clk);
    check_out(16'h0018, 4'hF, QAMCD_OTHER, 1'b1);
    // Common-input mode with no standby keeps every core on
    host_u.frame(1'b0, CONVERTER_CONTROL_ADDR, 16'h000C, FRAME_BITS, rd);
    @(negedge clk);
    check_out(16'h000C, 4'h0, QAMCD_OTHER, 1'b1);
    // Second reset mid-run
    rstn = 1'b0;
    repeat (2) @(negedge clk);
    check_out(16'h0000, 4'h0, QAMCD_FOUR, 1'b0);
    rstn = 1'b1;
    host_u.frame(1'b1, CONVERTER_CONTROL_ADDR, 16'h0000, FRAME_BITS, rd);
    `CHK("reset_reg", CONVERTER_CONTROL_RST, rd)
    give_verdict();
  end
endmodule : quad_adc_mode_control_decode_tb
